// File: logic/smf_pkg.sv
// shared constants and types for the management ram decode and flush controller
package smf_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] WIN_LO_OFS = 32'h00008000;
  localparam logic [31:0] WIN_HI_OFS = 32'h0000FFFF;
  localparam logic [31:0] BASE_RESET = 32'h00030000;
  // cache policy codes for normal memory and management ram
  localparam logic [1:0] POL_UC = 2'h0;
  localparam logic [1:0] POL_WT = 2'h1;
  localparam logic [1:0] POL_WB = 2'h2;
  // least lead of flush over the interrupt in an asynchronous system
  localparam int FLUSH_LEAD_CYC = 1;
  typedef enum {ST_IDLE, ST_LEAD, ST_ENTRY, ST_ACTIVE, ST_EXIT} smf_state_e;
endpackage

// File: logic/smf_dec_if.sv
// bundle between the controller and its address decoder
`timescale 1ns/1ns
interface smf_dec_if;
  logic [31:0] addr;
  logic [31:0] base;
  logic in_win;
  modport ctl (output addr, output base, input in_win);
  modport dec (input addr, input base, output in_win);
endinterface

// File: logic/smf_win_dec.sv
// management ram window decoder
`timescale 1ns/1ns
module smf_win_dec (
  smf_dec_if.dec d
);
  wire [31:0] lo = d.base + smf_pkg::WIN_LO_OFS;
  wire [31:0] hi = d.base + smf_pkg::WIN_HI_OFS;
  assign d.in_win = (d.addr >= lo) && (d.addr <= hi);
endmodule

// File: logic/smf_ctrl.sv
// management ram decode, guard and flush sequencing controller
`timescale 1ns/1ns
module smf_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_mgmt_req,
  input wire logic i_async_sys,
  input wire logic i_overlaid,
  input wire logic [1:0] i_norm_pol,
  input wire logic [1:0] i_ram_pol,
  input wire logic [31:0] i_mgmt_base_addr,
  input wire logic i_boot_open_set,
  input wire logic i_boot_open_clr,
  input wire logic i_mgmt_mode_active_out,
  input wire logic i_flush_ack,
  input wire logic i_cyc_start,
  input wire logic [31:0] i_cyc_addr,
  input wire logic i_cyc_code,
  input wire logic i_cyc_snoop_wb,
  input wire logic i_cyc_repl_wb,
  input wire logic i_cyc_alt_master,
  input wire logic i_cyc_done,
  input wire logic i_mem_ready,
  input wire logic i_l2_flush_done,
  input wire logic i_wbuf_empty,
  output logic o_mgmt_interrupt_in_n,
  output logic o_flush_n,
  output logic o_l2_flush,
  output logic o_cache_enable_in_n,
  output logic o_burst_ready_in_n,
  output logic o_ext_write_buffer_empty_in_n,
  output logic o_sel_mgmt_ram,
  output logic o_sel_normal,
  output logic o_cfg_wb_ram
);
  smf_pkg::smf_state_e state_q, state_d;
  logic open_q;
  logic route_mgmt_q, route_mgmt_d;
  logic in_cyc_q;
  logic uncached_q, uncached_d;
  logic [31:0] addr_q;
  logic lead_q;

  smf_dec_if dec_if ();
  assign dec_if.addr = i_cyc_start ? i_cyc_addr : addr_q;
  assign dec_if.base = i_mgmt_base_addr;
  smf_win_dec u_dec (.d(dec_if.dec));

  // ------------------------------------------------------------
  // flush policy
  // ------------------------------------------------------------
  wire norm_cached = i_norm_pol != smf_pkg::POL_UC;
  wire entry_flush = i_overlaid && norm_cached;
  wire exit_flush = i_overlaid && (i_ram_pol == smf_pkg::POL_WT);
  assign o_cfg_wb_ram = i_ram_pol == smf_pkg::POL_WB; // flagged, never honoured as wb

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      smf_pkg::ST_IDLE: begin
        if (i_mgmt_req && entry_flush && i_async_sys) begin
          state_d = smf_pkg::ST_LEAD;
        end else if (i_mgmt_req) begin
          state_d = smf_pkg::ST_ENTRY;
        end
      end
      smf_pkg::ST_LEAD: state_d = smf_pkg::ST_ENTRY;
      smf_pkg::ST_ENTRY: begin
        if (i_mgmt_mode_active_out) begin
          state_d = smf_pkg::ST_ACTIVE;
        end
      end
      smf_pkg::ST_ACTIVE: begin
        if (!i_mgmt_mode_active_out && exit_flush) begin
          state_d = smf_pkg::ST_EXIT;
        end else if (!i_mgmt_mode_active_out) begin
          state_d = smf_pkg::ST_IDLE;
        end
      end
      smf_pkg::ST_EXIT: begin
        if (i_flush_ack) begin
          state_d = smf_pkg::ST_IDLE;
        end
      end
      default: state_d = smf_pkg::ST_IDLE;
    endcase
  end

  wire in_entry = state_q == smf_pkg::ST_ENTRY;
  wire flush_now = (state_q == smf_pkg::ST_LEAD) || (in_entry && entry_flush && !lead_q)
    || (state_q == smf_pkg::ST_EXIT);
  // flush and interrupt together in a synchronous system, flush first if async
  assign o_flush_n = !(flush_now || (state_q == smf_pkg::ST_IDLE && i_mgmt_req && entry_flush));
  assign o_mgmt_interrupt_in_n = !(in_entry || (state_q == smf_pkg::ST_IDLE && i_mgmt_req
    && !(entry_flush && i_async_sys)));
  assign o_l2_flush = !o_flush_n;
  assign o_ext_write_buffer_empty_in_n = !i_wbuf_empty;

  // lines fetched after acknowledge and before entry stay uncached
  always_comb begin
    uncached_d = uncached_q;
    if (i_flush_ack && in_entry) begin
      uncached_d = 1'b1;
    end else if (state_q != smf_pkg::ST_ENTRY) begin
      uncached_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  // window reachable by the processor in mode or while boot holds it open
  wire win_ok = dec_if.in_win && !i_cyc_alt_master
    && (i_mgmt_mode_active_out || open_q);
  // writebacks are always steered to normal memory, so a mode-active edge
  // mid-cycle cannot split one transfer across spaces
  wire wb_cyc = i_cyc_snoop_wb || i_cyc_repl_wb;
  assign route_mgmt_d = i_cyc_start ? (win_ok && !wb_cyc) : route_mgmt_q;
  assign o_sel_mgmt_ram = in_cyc_q && route_mgmt_q;
  assign o_sel_normal = in_cyc_q && !route_mgmt_q;
  // every fetch ends, even one outside the window
  assign o_burst_ready_in_n = !(in_cyc_q && i_mem_ready);
  assign o_cache_enable_in_n = uncached_q || (in_cyc_q && route_mgmt_q
    && i_ram_pol == smf_pkg::POL_UC) || (in_cyc_q && !route_mgmt_q
    && i_norm_pol == smf_pkg::POL_UC);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= smf_pkg::ST_IDLE;
      open_q <= 1'b0;
      route_mgmt_q <= 1'b0;
      in_cyc_q <= 1'b0;
      uncached_q <= 1'b0;
      addr_q <= '0;
      lead_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (i_boot_open_set) begin
        open_q <= 1'b1;
      end else if (i_boot_open_clr) begin
        open_q <= 1'b0;
      end
      route_mgmt_q <= route_mgmt_d;
      if (i_cyc_start) begin
        in_cyc_q <= 1'b1;
        addr_q <= i_cyc_addr;
      end else if (i_cyc_done) begin
        in_cyc_q <= 1'b0;
      end
      uncached_q <= uncached_d;
      lead_q <= in_entry && (lead_q || i_flush_ack || !entry_flush);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  alt_master_blocked_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cyc_start && i_cyc_alt_master |=> !o_sel_mgmt_ram)
    else $error("alternate master reached management ram");
  snoop_wb_normal_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cyc_start && i_cyc_snoop_wb |=> !route_mgmt_q)
    else $error("snoop writeback routed to management ram");
  route_held_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    in_cyc_q && !i_cyc_start |=> route_mgmt_q == $past(route_mgmt_q))
    else $error("route changed inside a cycle");
  fetch_ready_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    in_cyc_q && i_mem_ready |-> !o_burst_ready_in_n)
    else $error("fetch left without burst ready");
  async_lead_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == smf_pkg::ST_LEAD |-> !o_flush_n && o_mgmt_interrupt_in_n)
    else $error("interrupt not led by flush");
  uncached_gap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    in_entry && i_flush_ack |=> o_cache_enable_in_n)
    else $error("line cached after flush acknowledge");
  exit_flush_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == smf_pkg::ST_ACTIVE && !i_mgmt_mode_active_out && exit_flush
    |=> !o_flush_n)
    else $error("exit flush missing");
  window_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cyc_start && !i_mgmt_mode_active_out && !open_q |=> !o_sel_mgmt_ram)
    else $error("window selected outside mode");
  code_fetch_ready_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cyc_start && i_cyc_code && !dec_if.in_win ##1 i_mem_ready |-> !o_burst_ready_in_n)
    else $error("stray code fetch left without burst ready");
  repl_wb_normal_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cyc_start && i_cyc_repl_wb |=> !route_mgmt_q)
    else $error("replacement writeback routed to management ram");
  sync_flush_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == smf_pkg::ST_IDLE && i_mgmt_req && entry_flush && !i_async_sys
    |-> !o_flush_n && !o_mgmt_interrupt_in_n)
    else $error("flush not raised with the interrupt");
  wb_ram_exit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_q == smf_pkg::ST_ACTIVE && i_ram_pol == smf_pkg::POL_WB
    |=> state_q != smf_pkg::ST_EXIT)
    else $error("exit flush run for writeback management ram");
endmodule

// File: tb/smf_cpu_model.sv
// processor model answering the flush and management interrupt pins
`timescale 1ns/1ns
module smf_cpu_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_smi_n,
  input wire logic i_flush_n,
  input wire logic i_ext_write_buffer_empty_in_n,
  input wire logic i_leave,
  output logic o_active,
  output logic o_flush_ack
);
  logic [3:0] fc_q;
  logic [3:0] ac_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fc_q <= 4'h0;
      ac_q <= 4'h0;
      o_active <= 1'b0;
      o_flush_ack <= 1'b0;
    end else begin
      // no flush of its own: only a requested one is acknowledged
      fc_q <= i_flush_n ? 4'h0 : fc_q + 4'h1;
      o_flush_ack <= (fc_q == 4'h3);
      // interrupt ignored while a flush is pending; delay stands for line prefetches
      ac_q <= (i_smi_n || !i_flush_n) ? 4'h0 : ac_q + {3'h0, ac_q != 4'hF};
      if (i_leave) begin
        o_active <= 1'b0;
      end else if (ac_q == 4'h4 && !i_ext_write_buffer_empty_in_n) begin
        o_active <= 1'b1;
      end
    end
  end
endmodule

// File: tb/smf_ctrl_tb.sv
// self-checking testbench for the management ram controller
`timescale 1ns/1ns
module smf_ctrl_tb;
  localparam logic [31:0] BASE = 32'h00040000;
  logic clk, rstn, req, as_r, ov_r, bs, bc, st, cd, sw, al, dn, rdy, wbe, leave, rw;
  logic [1:0] np_r, rp_r;
  logic [31:0] ad;
  logic smi_n, fl_n, l2f, ken_n, burst_ready_in_n, ext_write_buffer_empty_in_n, sel_m, sel_n, act, fack, wbr;
  logic [1:0] np_t [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
  logic [1:0] rp_t [7] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  int n_fail, n_tests, k;
  smf_ctrl i_smf_ctrl (.i_clk(clk), .i_resetn(rstn), .i_mgmt_req(req), .i_async_sys(as_r),
    .i_overlaid(ov_r), .i_norm_pol(np_r), .i_ram_pol(rp_r), .i_mgmt_base_addr(BASE),
    .i_boot_open_set(bs), .i_boot_open_clr(bc), .i_mgmt_mode_active_out(act),
    .i_flush_ack(fack), .i_cyc_start(st), .i_cyc_addr(ad), .i_cyc_code(cd),
    .i_cyc_snoop_wb(sw), .i_cyc_repl_wb(rw), .i_cyc_alt_master(al), .i_cyc_done(dn),
    .i_mem_ready(rdy), .i_l2_flush_done(1'b0), .i_wbuf_empty(wbe),
    .o_mgmt_interrupt_in_n(smi_n), .o_flush_n(fl_n), .o_l2_flush(l2f),
    .o_cache_enable_in_n(ken_n), .o_burst_ready_in_n(burst_ready_in_n),
    .o_ext_write_buffer_empty_in_n(ext_write_buffer_empty_in_n), .o_sel_mgmt_ram(sel_m),
    .o_sel_normal(sel_n), .o_cfg_wb_ram(wbr));
  smf_cpu_model i_smf_cpu_model (.i_clk(clk), .i_resetn(rstn), .i_smi_n(smi_n),
    .i_flush_n(fl_n), .i_ext_write_buffer_empty_in_n(ext_write_buffer_empty_in_n), .i_leave(leave), .o_active(act), .o_flush_ack(fack));
  // ----------------
  // tasks
  // ----------------
  task stop_test;
    begin
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string n, input logic e, input logic g);
    begin
      n_tests++;
      if (g !== e) begin
        $display("unexpected %s exp %b got %b", n, e, g);
        n_fail++;
      end
    end
  endtask
  task t_cyc(input logic [31:0] a, input logic alt, wb, code, em);
    begin
      @(negedge clk);
      st = 1; ad = a; al = alt; sw = wb; cd = code;
      @(negedge clk);
      st = 0;
      rdy = 1;
      dn = 1;
      #1;
      chk("sel_mgmt", em, sel_m);
      chk("sel_norm", !em, sel_n);
      chk("burst_ready_in_n", 1'b0, burst_ready_in_n);
      @(negedge clk);
      {dn, rdy, al, sw, cd} = '0;
    end
  endtask
  task t_mode(input logic ov, input logic [1:0] np, rp, input logic as);
    int tf, ts, i;
    logic ak;
    begin
      @(negedge clk);
      ov_r = ov; np_r = np; rp_r = rp; as_r = as; req = 1;
      tf = -1; ts = -1; ak = 0;
      for (i = 0; i < 40 && !act; i++) begin
        @(negedge clk);
        if (!fl_n && tf < 0) tf = i;
        if (!smi_n && ts < 0) ts = i;
        chk("l2_flush", !fl_n, l2f);
        if (ak) chk("ken_n", 1'b1, ken_n);
        ak = ak | fack;
      end
      req = 0;
      chk("active", 1'b1, act);
      if (!act) stop_test();
      chk("entry_flush", ov && np != 2'h0, tf >= 0);
      if (tf >= 0) chk("flush_lead", as, ts > tf);
      t_cyc(BASE + 32'h7FFF, 0, 0, 0, 0);
      t_cyc(BASE + 32'h8000, 0, 0, 0, 1);
      t_cyc(BASE + 32'hFFFF, 0, 0, 0, 1);
      t_cyc(BASE + 32'h10000, 0, 0, 1, 0);
      t_cyc(BASE + 32'h8000, 0, 1, 0, 0);
      t_cyc(BASE + 32'h8000, 1, 0, 0, 0);
      rw = 1;
      t_cyc(BASE + 32'h8000, 0, 0, 0, 0);
      rw = 0;
      @(negedge clk);
      leave = 1;
      @(negedge clk);
      leave = 0; tf = -1;
      for (i = 0; i < 20; i++) begin
        @(negedge clk);
        if (!fl_n) tf = i;
      end
      chk("exit_flush", ov && rp == 2'h1, tf >= 0);
      chk("smi_idle", 1'b1, smi_n);
      chk("cfg_wb", rp == 2'h2, wbr);
    end
  endtask
  task t_boot;
    begin
      t_cyc(BASE + 32'h8000, 0, 0, 1, 0);
      bs = 1;
      @(negedge clk);
      bs = 0;
      t_cyc(BASE + 32'h8000, 0, 0, 0, 1);
      t_cyc(BASE + 32'h8000, 1, 0, 0, 0);
      bc = 1;
      @(negedge clk);
      bc = 0;
      t_cyc(BASE + 32'h8000, 0, 0, 0, 0);
    end
  endtask
  // window opened by boot code must close again on a reset in mid-run
  task t_rst;
    begin
      @(negedge clk);
      bs = 1;
      @(negedge clk);
      bs = 0;
      rstn = 0;
      repeat (2) @(negedge clk);
      rstn = 1;
      chk("smi_mid_rst", 1'b1, smi_n);
      chk("flush_mid_rst", 1'b1, fl_n);
      chk("sel_mid_rst", 1'b0, sel_m);
      t_cyc(BASE + 32'h8000, 0, 0, 0, 0);
    end
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, req, as_r, ov_r, bs, bc, st, cd, sw, al, dn, rdy, leave, rw} = '0;
    np_r = 2'h0; rp_r = 2'h0; ad = 32'h0; wbe = 1; n_fail = 0; n_tests = 0;
    repeat (5) @(negedge clk);
    rstn = 1;
    chk("ext_write_buffer_empty_in_n", 1'b0, ext_write_buffer_empty_in_n);
    chk("smi_rst", 1'b1, smi_n);
    t_boot();
    t_rst();
    for (k = 0; k < 14; k++) t_mode(k > 6, np_t[k % 7], rp_t[k % 7], k[0]);
    stop_test();
  end
endmodule
